// ==== logic/ibcc_params.svh ====
`ifndef IBCC_PARAMS_SVH
`define IBCC_PARAMS_SVH

// ****************************************************************
// bus timing
// ****************************************************************
`define IBCC_CLOCK_NS       40
`define IBCC_CMD_MIN_NS     120
`define IBCC_CMD_CYCLES     ((`IBCC_CMD_MIN_NS + `IBCC_CLOCK_NS - 1) / `IBCC_CLOCK_NS)
`define IBCC_RESET_MIN_NS   100000
`define IBCC_RESET_CYCLES   ((`IBCC_RESET_MIN_NS + `IBCC_CLOCK_NS - 1) / `IBCC_CLOCK_NS)

// ****************************************************************
// address and lane layout
// ****************************************************************
`define IBCC_ADDR_WIDTH     12
`define IBCC_DATA_WIDTH     16
`define IBCC_KBD_FIRST      10'h060
`define IBCC_KBD_LAST       10'h06E

`endif

// ==== logic/ibcc_pkg.sv ====
package ibcc_pkg;

    // bus cycle sequencer states
    typedef enum logic [1:0] {
        ibcc_idle,
        ibcc_addr,
        ibcc_cmd,
        ibcc_end
    } ibcc_state_type;

endpackage : ibcc_pkg

// ==== logic/ibcc_reset_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ibcc_params.svh"

module ibcc_reset_gen #(
    parameter int RESET_CYCLES = `IBCC_RESET_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pll_locked,
    output var  logic bus_reset_out
);

    // ****************************************************************
    // bus reset pulse: held until clocks settle, then a least width
    // ****************************************************************
    logic [31:0] width_count;

    always_ff @(posedge clock) begin
        if (reset) begin
            width_count   <= 32'h0000_0000;
            bus_reset_out <= 1'b1;
        end else if (!pll_locked) begin
            width_count   <= 32'h0000_0000;  // RL11
            bus_reset_out <= 1'b1;
        end else if (width_count < 32'(RESET_CYCLES - 1)) begin
            width_count   <= width_count + 32'h0000_0001;
        end else begin
            bus_reset_out <= 1'b0;           // RL11
        end
    end

endmodule : ibcc_reset_gen
`default_nettype wire

// ==== logic/ibcc_kbd_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ibcc_params.svh"

module ibcc_kbd_decode (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        io_cycle,
    input  wire logic [9:0]  io_addr,
    output var  logic        kbd_ctrl_select_n
);

    // ****************************************************************
    // keyboard controller select: even ports in the 060h..06Eh block
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            kbd_ctrl_select_n <= 1'b1;
        end else begin
            kbd_ctrl_select_n <= !(io_cycle && !io_addr[0]
                                   && io_addr >= `IBCC_KBD_FIRST
                                   && io_addr <= `IBCC_KBD_LAST);  // RL15
        end
    end

endmodule : ibcc_kbd_decode
`default_nettype wire

// ==== logic/ibcc_bus_cycle_control.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ibcc_params.svh"

// How it works
// RL1 - low lane driven out raises low direction
// RL2 - high lane driven out raises high direction
// RL3 - wait states while channel ready is low
// RL4 - io size16 low makes a 16-bit access
// RL5 - no size16 means 8-bit, low lane only
// RL6 - io and memory size16 are ORed internally
// RL7 - io read strobe low during io reads
// RL8 - io write strobe low during io writes
// RL9 - memory read strobe low during memory reads
// RL10 - memory write strobe low during memory writes
// RL11 - bus reset out resets cards, width adjustable
// RL12 - latched low address drives sys addr low
// RL13 - high byte enable low for upper-lane bytes
// RL14 - last-transfer flag on zero count, else test
// RL15 - keyboard select for even 060h..06Eh ports
// RL16 - strobe ends after ready seen; outputs steady
module ibcc_bus_cycle_control
    import ibcc_pkg::*;
#(
    parameter int ADDR_WIDTH   = `IBCC_ADDR_WIDTH,
    parameter int CMD_CYCLES   = `IBCC_CMD_CYCLES,
    parameter int RESET_CYCLES = `IBCC_RESET_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  pll_locked,
    input  wire logic                  req_valid,
    input  wire logic                  req_write,
    input  wire logic                  req_memory,
    input  wire logic                  req_word,
    input  wire logic [ADDR_WIDTH-1:0] req_addr,
    input  wire logic [15:0]           req_wdata,
    output var  logic                  req_ready,
    output var  logic                  rsp_done,
    output var  logic [15:0]           rsp_rdata,
    input  wire logic                  dma_active,
    input  wire logic                  dma_count_zero,
    input  wire logic                  test_port_enable,
    output var  logic                  dma_last_transfer,
    output var  logic                  dma_last_transfer_oe,
    input  wire logic                  channel_ready,
    input  wire logic                  io_size16_n,
    input  wire logic                  mem_size16_n,
    output var  logic                  io_read_strobe_n,
    output var  logic                  io_write_strobe_n,
    output var  logic                  mem_read_strobe_n,
    output var  logic                  mem_write_strobe_n,
    output var  logic [ADDR_WIDTH-1:0] sys_addr_low,
    output var  logic                  high_byte_enable_n,
    output var  logic                  low_byte_out_dir,
    output var  logic                  high_byte_out_dir,
    input  wire logic [15:0]           data_in,
    output var  logic [15:0]           data_out,
    output var  logic                  data_oe_low,
    output var  logic                  data_oe_high,
    output var  logic                  bus_reset_out,
    output var  logic                  kbd_ctrl_select_n
);

    // ****************************************************************
    // lane helpers
    // ****************************************************************

    // high lane carries data on a wide target for odd bytes or words
    function automatic logic lane_high(input logic wide, input logic odd,
                                       input logic word);
        lane_high = wide && (odd || word);
    endfunction : lane_high

    // low lane carries data for even accesses and every narrow access
    function automatic logic lane_low(input logic wide, input logic odd);
        lane_low = !wide || !odd;
    endfunction : lane_low

    // ****************************************************************
    // cycle state
    // ****************************************************************
    ibcc_state_type           state;
    ibcc_state_type           next_state;
    logic [7:0]               cmd_count;
    logic                     cyc_write;
    logic                     cyc_memory;
    logic                     cyc_word;
    logic                     cyc_second;
    logic                     cyc_wide;
    logic [ADDR_WIDTH-1:0]    cyc_addr;
    logic [15:0]              cyc_wdata;
    logic                     next_wide;
    logic                     need_second;
    logic                     ready_seen;

    // size indications from io and memory targets are merged
    assign next_wide   = !io_size16_n || !mem_size16_n;          // RL6 RL4 RL5
    assign need_second = cyc_word && !cyc_wide && !cyc_second;   // RL5
    assign ready_seen  = (cmd_count == 8'h00) && channel_ready;  // RL3

    // next state of the sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ibcc_idle: begin
                if (req_valid && req_ready) begin
                    next_state = ibcc_addr;
                end
            end
            ibcc_addr: begin
                next_state = ibcc_cmd;
            end
            ibcc_cmd: begin
                if (ready_seen) begin
                    next_state = ibcc_end;   // RL16
                end
            end
            ibcc_end: begin
                next_state = need_second ? ibcc_addr : ibcc_idle;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ibcc_idle;
        end else begin
            state <= next_state;
        end
    end

    // command length counter; wait states extend past it
    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_count <= 8'h00;
        end else if (state == ibcc_addr) begin
            cmd_count <= 8'(CMD_CYCLES - 1);
        end else if (state == ibcc_cmd && cmd_count != 8'h00) begin
            cmd_count <= cmd_count - 8'h01;
        end
    end

    // ****************************************************************
    // request capture and address
    // ****************************************************************

    // request fields held for the whole cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            cyc_write  <= 1'b0;
            cyc_memory <= 1'b0;
            cyc_word   <= 1'b0;
            cyc_second <= 1'b0;
            cyc_addr   <= '0;
            cyc_wdata  <= 16'h0000;
        end else if (state == ibcc_idle && next_state == ibcc_addr) begin
            cyc_write  <= req_write;
            cyc_memory <= req_memory;
            cyc_word   <= req_word;
            cyc_second <= 1'b0;
            cyc_addr   <= req_word ? {req_addr[ADDR_WIDTH-1:1], 1'b0} : req_addr;
            cyc_wdata  <= req_wdata;
        end else if (state == ibcc_end && need_second) begin
            cyc_second <= 1'b1;
            cyc_addr   <= {cyc_addr[ADDR_WIDTH-1:1], 1'b1};  // RL5
        end
    end

    // address and byte enable change only when a cycle or its second byte cycle is opened
    always_ff @(posedge clock) begin
        if (reset) begin
            sys_addr_low       <= '0;
            high_byte_enable_n <= 1'b1;
        end else if (state == ibcc_idle && next_state == ibcc_addr) begin
            sys_addr_low       <= req_word ? {req_addr[ADDR_WIDTH-1:1], 1'b0}
                                           : req_addr;                 // RL12 RL16
            high_byte_enable_n <= !(req_word || req_addr[0]);          // RL13
        end else if (state == ibcc_end && need_second) begin
            sys_addr_low       <= {cyc_addr[ADDR_WIDTH-1:1], 1'b1};    // RL12
            high_byte_enable_n <= 1'b0;                                // RL13
        end
    end

    // latched size of the target, sampled once the address has settled
    always_ff @(posedge clock) begin
        if (reset) begin
            cyc_wide <= 1'b0;
        end else if (state == ibcc_addr) begin
            cyc_wide <= next_wide;    // RL4 RL5 RL6
        end
    end

    // ****************************************************************
    // command strobes
    // ****************************************************************

    // one strobe per cycle, asserted through all wait states
    always_ff @(posedge clock) begin
        if (reset) begin
            io_read_strobe_n   <= 1'b1;
            io_write_strobe_n  <= 1'b1;
            mem_read_strobe_n  <= 1'b1;
            mem_write_strobe_n <= 1'b1;
        end else if (state == ibcc_addr) begin
            io_read_strobe_n   <= !(!cyc_memory && !cyc_write);  // RL7
            io_write_strobe_n  <= !(!cyc_memory && cyc_write);   // RL8
            mem_read_strobe_n  <= !(cyc_memory && !cyc_write);   // RL9
            mem_write_strobe_n <= !(cyc_memory && cyc_write);    // RL10
        end else if (state == ibcc_cmd && ready_seen) begin
            io_read_strobe_n   <= 1'b1;   // RL16
            io_write_strobe_n  <= 1'b1;
            mem_read_strobe_n  <= 1'b1;
            mem_write_strobe_n <= 1'b1;
        end
    end

    // ****************************************************************
    // data lanes and buffer direction
    // ****************************************************************

    // write data steered; odd bytes copied to the low lane
    always_ff @(posedge clock) begin
        if (reset) begin
            data_out <= 16'h0000;
        end else if (state == ibcc_addr) begin
            data_out <= {cyc_wdata[15:8],
                         cyc_addr[0] ? cyc_wdata[15:8] : cyc_wdata[7:0]};
        end
    end

    // drivers and transceiver directions follow the lanes in use
    always_ff @(posedge clock) begin
        if (reset) begin
            data_oe_low       <= 1'b0;
            data_oe_high      <= 1'b0;
            low_byte_out_dir  <= 1'b0;
            high_byte_out_dir <= 1'b0;
        end else if (state == ibcc_addr) begin
            data_oe_low       <= cyc_write && lane_low(next_wide, cyc_addr[0]);
            data_oe_high      <= cyc_write
                                 && lane_high(next_wide, cyc_addr[0], cyc_word);
            low_byte_out_dir  <= cyc_write && lane_low(next_wide, cyc_addr[0]);  // RL1
            high_byte_out_dir <= cyc_write
                                 && lane_high(next_wide, cyc_addr[0], cyc_word); // RL2
        end else if (state == ibcc_cmd && ready_seen) begin
            data_oe_low       <= 1'b0;
            data_oe_high      <= 1'b0;
            low_byte_out_dir  <= 1'b0;   // RL1
            high_byte_out_dir <= 1'b0;   // RL2
        end
    end

    // read data taken as the strobe ends; narrow bytes come on low lane
    always_ff @(posedge clock) begin
        if (reset) begin
            rsp_rdata <= 16'h0000;
        end else if (state == ibcc_cmd && ready_seen && !cyc_write) begin
            if (cyc_wide) begin
                if (lane_low(1'b1, cyc_addr[0])) begin
                    rsp_rdata[7:0] <= data_in[7:0];
                end
                if (lane_high(1'b1, cyc_addr[0], cyc_word)) begin
                    rsp_rdata[15:8] <= data_in[15:8];
                end
            end else if (cyc_addr[0]) begin
                rsp_rdata[15:8] <= data_in[7:0];   // RL5
            end else begin
                rsp_rdata[7:0] <= data_in[7:0];    // RL5
            end
        end
    end

    // ****************************************************************
    // request handshake
    // ****************************************************************

    // ready only when idle and the bus is out of reset; done one pulse
    always_ff @(posedge clock) begin
        if (reset) begin
            req_ready <= 1'b0;
            rsp_done  <= 1'b0;
        end else begin
            req_ready <= (next_state == ibcc_idle) && !bus_reset_out && pll_locked;
            rsp_done  <= (state == ibcc_end) && !need_second;
        end
    end

    // ****************************************************************
    // dma last transfer and test pin sharing
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            dma_last_transfer    <= 1'b0;
            dma_last_transfer_oe <= 1'b1;
        end else begin
            dma_last_transfer    <= !test_port_enable && dma_active
                                    && dma_count_zero;       // RL14
            dma_last_transfer_oe <= !test_port_enable;       // RL14
        end
    end

    // ****************************************************************
    // bus reset and keyboard select
    // ****************************************************************
    ibcc_reset_gen #(
        .RESET_CYCLES (RESET_CYCLES)
    ) u_reset_gen (
        .clock         (clock),
        .reset         (reset),
        .pll_locked    (pll_locked),
        .bus_reset_out (bus_reset_out)
    );

    ibcc_kbd_decode u_kbd_decode (
        .clock             (clock),
        .reset             (reset),
        .io_cycle          (!cyc_memory && (state == ibcc_cmd)),
        .io_addr           (cyc_addr[9:0]),
        .kbd_ctrl_select_n (kbd_ctrl_select_n)
    );

endmodule : ibcc_bus_cycle_control
`default_nettype wire

// ==== dv/ibcc_bus_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// bus cycle checker
// ****************************************************************
module ibcc_bus_monitor #(
    parameter int ADDR_WIDTH   = 12,
    parameter int RESET_CYCLES = 8
) (
    input wire logic                  clock,
    input wire logic                  reset,
    input wire logic                  pll_locked,
    input wire logic                  req_valid,
    input wire logic                  req_ready,
    input wire logic                  rsp_done,
    input wire logic                  dma_active,
    input wire logic                  dma_count_zero,
    input wire logic                  test_port_enable,
    input wire logic                  dma_last_transfer,
    input wire logic                  dma_last_transfer_oe,
    input wire logic                  channel_ready,
    input wire logic                  io_read_strobe_n,
    input wire logic                  io_write_strobe_n,
    input wire logic                  mem_read_strobe_n,
    input wire logic                  mem_write_strobe_n,
    input wire logic [ADDR_WIDTH-1:0] sys_addr_low,
    input wire logic                  high_byte_enable_n,
    input wire logic                  low_byte_out_dir,
    input wire logic                  high_byte_out_dir,
    input wire logic                  data_oe_low,
    input wire logic                  data_oe_high,
    input wire logic                  bus_reset_out,
    input wire logic                  kbd_ctrl_select_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic        cmd;
    logic        io_cmd;
    logic [15:0] lock_cnt;
    // any command strobe low
    assign cmd = !(io_read_strobe_n && io_write_strobe_n && mem_read_strobe_n
                   && mem_write_strobe_n);
    assign io_cmd = !(io_read_strobe_n && io_write_strobe_n);
    // cycles since the clocks became stable
    always_ff @(posedge clock) begin
        if (reset || !pll_locked) lock_cnt <= 16'h0000;
        else if (lock_cnt != 16'hffff) lock_cnt <= lock_cnt + 16'h0001;
    end
    function automatic logic kbd_hit(input logic [ADDR_WIDTH-1:0] a);
        return !a[0] && a[9:0] >= 10'h060 && a[9:0] <= 10'h06e;
    endfunction : kbd_hit
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_answer;
        !rsp_done [*4] ##[1:400] rsp_done;
    endsequence
    a_low_dir_drive: assert property ((low_byte_out_dir == data_oe_low)
        && (!low_byte_out_dir || !(io_write_strobe_n && mem_write_strobe_n)))
        else $error("low direction wrong");
    a_high_dir_drive: assert property (high_byte_out_dir == data_oe_high)
        else $error("high direction wrong");
    a_wait_hold: assert property (cmd && !channel_ready |=> cmd)
        else $error("strobe ended while not ready");
    a_end_after_ready: assert property ($fell(cmd) |-> $past(channel_ready))
        else $error("strobe ended without ready");
    a_addr_steady: assert property (cmd && $past(cmd) |-> $stable(sys_addr_low)
        && $stable(high_byte_enable_n))
        else $error("address moved in command");
    a_upper_lane_enable: assert property (data_oe_high |-> !high_byte_enable_n)
        else $error("upper lane without byte enable");
    a_one_cmd: assert property (cmd |-> $onehot({!io_read_strobe_n,
        !io_write_strobe_n, !mem_read_strobe_n, !mem_write_strobe_n}))
        else $error("two command strobes");
    a_last_xfer_flag: assert property (!$past(reset) |-> dma_last_transfer ==
        $past(!test_port_enable && dma_active && dma_count_zero)
        && dma_last_transfer_oe == $past(!test_port_enable))
        else $error("last transfer flag wrong");
    a_reset_hold: assert property (!pll_locked |=> bus_reset_out && !req_ready)
        else $error("bus reset not held");
    a_reset_width: assert property ($fell(bus_reset_out) |-> lock_cnt >= RESET_CYCLES - 1)
        else $error("bus reset too short");
    a_kbd_decode: assert property (!kbd_ctrl_select_n |-> $past(io_cmd
        && kbd_hit(sys_addr_low)))
        else $error("keyboard select outside range");
    a_done_after: assert property (s_take |=> s_answer)
        else $error("request not answered in time");
endmodule : ibcc_bus_monitor

bind ibcc_bus_cycle_control ibcc_bus_monitor #(
    .ADDR_WIDTH(ADDR_WIDTH), .RESET_CYCLES(RESET_CYCLES)) u_monitor (.*);
`default_nettype wire

// ==== dv/ibcc_slave_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// expansion card model: 16-bit window when address bit 11 is set
// ****************************************************************
module ibcc_slave_model (
    input  wire logic        clock,
    input  wire logic [1:0]  wait_cycles,
    input  wire logic        io_read_strobe_n,
    input  wire logic        io_write_strobe_n,
    input  wire logic        mem_read_strobe_n,
    input  wire logic        mem_write_strobe_n,
    input  wire logic [11:0] sys_addr_low,
    input  wire logic        high_byte_enable_n,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe_high,
    output var  logic        channel_ready,
    output var  logic        io_size16_n,
    output var  logic        mem_size16_n,
    output var  logic [15:0] data_in,
    output var  logic        lane_error
);
    logic [7:0]  mem [0:4095];
    logic [1:0]  cnt;
    logic [7:0]  noise = 8'h00;
    logic [11:0] ev;
    logic        rd;
    logic        wr;
    logic        wide;
    initial lane_error = 1'b0;
    assign rd = !(io_read_strobe_n && mem_read_strobe_n);
    assign wr = !(io_write_strobe_n && mem_write_strobe_n);
    assign wide = sys_addr_low[11];
    assign ev = {sys_addr_low[11:1], 1'b0};
    // size lines low only while the card decodes its own address
    assign io_size16_n = !(wide && !sys_addr_low[10]);
    assign mem_size16_n = !(wide && sys_addr_low[10]);
    assign channel_ready = !(rd || wr) || cnt >= wait_cycles;
    // undriven lanes carry a changing pattern
    assign data_in = !rd ? {noise, ~noise} : wide ? {mem[ev | 12'h001], mem[ev]}
                   : {noise, mem[sys_addr_low]};
    // wait counter and write latch
    always @(posedge clock) begin
        noise <= noise + 8'h5b;
        cnt <= !(rd || wr) ? 2'h0 : (cnt == 2'h3) ? cnt : cnt + 2'h1;
        if (wr && wide && !high_byte_enable_n) mem[sys_addr_low | 12'h001] <= data_out[15:8];
        if (wr && !(wide && sys_addr_low[0])) mem[wide ? ev : sys_addr_low] <= data_out[7:0];
        if (wr && !wide && data_oe_high) lane_error <= 1'b1;
    end
endmodule : ibcc_slave_model
`default_nettype wire

// ==== dv/isa_bus_cycle_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// bench top
// ****************************************************************
module isa_bus_cycle_control_tb_top;
    logic clock = 1'b0, reset = 1'b1, pll_locked = 1'b0, req_valid = 1'b0;
    logic req_write = 1'b0, req_memory = 1'b0, req_word = 1'b0;
    logic dma_active = 1'b0, dma_count_zero = 1'b0, test_port_enable = 1'b0;
    logic [11:0] req_addr = 12'h000, a, sys_addr_low;
    logic [15:0] req_wdata = 16'h0000, d, rsp_rdata, data_in, data_out;
    logic [1:0] wait_cycles = 2'h0;
    logic req_ready, rsp_done, dma_last_transfer, dma_last_transfer_oe, channel_ready;
    logic io_size16_n, mem_size16_n, io_read_strobe_n, io_write_strobe_n, m, wd;
    logic mem_read_strobe_n, mem_write_strobe_n, high_byte_enable_n, low_byte_out_dir;
    logic high_byte_out_dir, data_oe_low, data_oe_high, bus_reset_out, kbd_ctrl_select_n;
    logic lane_error, kbd_seen;
    logic [7:0] ref_mem [0:4095];
    logic [31:0] exp_q [$], got;
    logic [11:0] kbd_list [8] = '{12'h060, 12'h061, 12'h06e, 12'h06f,
                                  12'h070, 12'h05e, 12'h860, 12'hc6c};
    int mismatches = 0, n_tests = 0, cycles = 0;
    always #20 clock = ~clock;
    ibcc_bus_cycle_control #(.RESET_CYCLES(8)) u_dut (.*);
    ibcc_slave_model u_slave (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic wait_ready;
        int n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({15'h0000, req_ready}, 16'h0001);
    endtask : wait_ready
    function automatic logic kbd_hit(input logic [11:0] x);
        return !x[0] && x[9:0] >= 10'h060 && x[9:0] <= 10'h06e;
    endfunction : kbd_hit
    // one request: note the expected answer, hand it over, check the bus side
    task automatic do_req(input logic w, mm, ww, input logic [11:0] ad, input logic [15:0] dd);
        logic [11:0] e;
        logic [15:0] k;
        int n = 0;
        e = ww ? {ad[11:1], 1'b0} : ad;
        k = ww ? 16'hffff : ad[0] ? 16'hff00 : 16'h00ff;
        if (w && k[0]) ref_mem[e] = dd[7:0];
        if (w && k[8]) ref_mem[e | 12'h001] = dd[15:8];
        exp_q.push_back(w ? 32'h0000_0000 : {k, {ref_mem[e | 12'h001], ref_mem[e]} & k});
        wait_ready;
        wait_cycles = 2'($urandom);
        {req_write, req_memory, req_word, req_addr, req_wdata} = {w, mm, ww, ad, dd};
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        while (io_read_strobe_n & io_write_strobe_n & mem_read_strobe_n & mem_write_strobe_n
               && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({12'h000, io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n,
               mem_write_strobe_n}, {12'h000, ~(4'b1000 >> {mm, w})});
        check({4'h0, sys_addr_low}, {4'h0, e});
        check({15'h0000, high_byte_enable_n}, {15'h0000, !(ww || ad[0])});
    endtask : do_req
    // answer watcher, cycle count and hang limit
    always @(posedge clock) begin
        cycles++;
        if (kbd_ctrl_select_n === 1'b0) kbd_seen = 1'b1;
        if (rsp_done === 1'b1) begin
            check({15'h0000, exp_q.size() == 0}, 16'h0000);
            if (exp_q.size() != 0) begin
                got = exp_q.pop_front();
                if (got[31:16] != 16'h0000) check(rsp_rdata & got[31:16], got[15:0]);
            end
        end
        if (cycles == 30000) begin
            mismatches++;
            stop_test;
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'hed1e));
        repeat (12) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({14'h0000, bus_reset_out, req_ready}, 16'h0002);
        pll_locked = 1'b1;
        for (int i = 0; i < 60; i++) begin
            a = (i == 0) ? 12'hfff : 12'($urandom);
            d = 16'($urandom);
            {m, wd} = 2'($urandom);
            do_req(1'b1, m, wd, a, d);
            do_req(1'b0, m, wd, a, 16'($urandom));
        end
        foreach (kbd_list[j]) begin
            wait_ready;
            kbd_seen = 1'b0;
            do_req(1'b1, 1'b0, 1'b0, kbd_list[j], 16'h5aa5);
            wait_ready;
            check({15'h0000, kbd_seen}, {15'h0000, kbd_hit(kbd_list[j])});
        end
        for (int j = 0; j < 8; j++) begin
            {test_port_enable, dma_active, dma_count_zero} = 3'(j);
            @(posedge clock);
            #1;
            check({14'h0000, dma_last_transfer, dma_last_transfer_oe},
                  {14'h0000, j == 3, j < 4});
        end
        pll_locked = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check({14'h0000, bus_reset_out, req_ready}, 16'h0002);
        pll_locked = 1'b1;
        do_req(1'b1, 1'b1, 1'b1, 12'h802, 16'hc33c);
        do_req(1'b0, 1'b1, 1'b1, 12'h802, 16'h0000);
        wait_ready;
        check({15'h0000, lane_error}, 16'h0000);
        stop_test;
    end
endmodule : isa_bus_cycle_control_tb_top
`default_nettype wire
